// [verilog/ttd_pkg.sv]
// package for the trigger timing decode and emulation block
// assumes a single 50 MHz bunch clock domain
package ttd_pkg;
    localparam int          CLK_MHZ          = 50;
    localparam int          ORBIT_LAST_BX    = 3564;
    localparam logic [11:0] ORBIT_LAST       = 12'h0_DEC;
    localparam int          TBL_AW           = 12;
    localparam int          TBL_DEPTH        = 4096;
    localparam int          PAT_TRIG_BIT     = 0;
    localparam int          PAT_MONEV_BIT    = 1;
    localparam int          PAT_MONST_BIT    = 2;
    localparam int          PAT_BCRES_BIT    = 3;
    localparam int          DLY_SYS_LSB      = 0;
    localparam int          DLY_USR_LSB      = 4;
    localparam int          DLY_MAX          = 16;
    localparam int          Q_DEPTH          = 16;
    localparam logic [4:0]  Q_WARN_LEVEL     = 5'h0_00C;
    localparam logic [4:0]  Q_FULL_LEVEL     = 5'h0_010;
    localparam int          PWRUP_US         = 100;
    localparam int          PWRUP_CYC        = PWRUP_US * CLK_MHZ;
    localparam int          READOUT_DRIVER_ENABLE_US         = 200;
    localparam int          READOUT_DRIVER_ENABLE_CYC        = READOUT_DRIVER_ENABLE_US * CLK_MHZ;
    localparam int          RX_RST_CYC       = 16;
    localparam logic [1:0]  XSEL_RX_ALL      = 2'h0;
    localparam logic [1:0]  XSEL_PLL_BACK    = 2'h3;
    localparam logic [1:0]  XSEL_FORBIDDEN   = 2'h2;
    localparam logic [1:0]  RX_CTRL_EVONLY   = 2'h0;

    typedef struct packed {
        logic [7:0] brcst;
        logic       trig;
        logic       dbl_err;
        logic       sgl_err;
    } ttd_rx_t;

    typedef struct packed {
        logic       trig;
        logic       mon_event;
        logic       mon_stat;
        logic [11:0] bx;
        logic [23:0] ev;
    } ttd_req_t;
endpackage

// [verilog/ttd_delay.sv]
// coarse delay line in bunch-crossing cycles, 0..15
// assumes data on the same clock as the instantiating block
`timescale 1ns/1ps
module ttd_delay #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic [3:0]   dly_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] pipe_ff [ttd_pkg::DLY_MAX];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < ttd_pkg::DLY_MAX; i++) begin
                pipe_ff[i] <= '0;
            end
        end else begin
            pipe_ff[0] <= d_in;
            for (int i = 1; i < ttd_pkg::DLY_MAX; i++) begin
                pipe_ff[i] <= pipe_ff[i-1];
            end
        end
    end

    // zero delay still costs one register stage
    assign q_out = pipe_ff[dly_in];
endmodule

// [verilog/ttd_top.sv]
// timing decode, coarse delays, local counters, emulation tables
// assumes receiver pins are asynchronous; host controls are same-clock logic
`timescale 1ns/1ps
module ttd_top #(
    parameter int PWRUP_CYC = ttd_pkg::PWRUP_CYC,
    parameter int READOUT_DRIVER_ENABLE_CYC = ttd_pkg::READOUT_DRIVER_ENABLE_CYC
) (
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    input  wire ttd_pkg::ttd_rx_t    rx_in,
    input  wire logic [23:0]         rx_event_in,
    input  wire logic [11:0]         rx_bunch_number_in,
    input  wire logic [7:0]          coarse_dly_in,
    input  wire logic                emulate_in,
    input  wire logic                host_trig_in,
    input  wire logic                host_rx_reset_in,
    input  wire logic [1:0]          cross_sel_in,
    input  wire logic [1:0]          phase_sel_in,
    input  wire logic                flags_clr_in,
    input  wire logic                tbl_we_in,
    input  wire logic [11:0]         tbl_addr_in,
    input  wire logic [3:0]          tbl_pat_in,
    input  wire logic [15:0]         tbl_cmd_in,
    input  wire logic                q_pop_in,
    output ttd_pkg::ttd_req_t        req_out,
    output logic                     req_valid_out,
    output logic                     ro_reset_out,
    output logic                     bunch_count_reset_out,
    output logic                     event_count_reset_out,
    output logic [3:0]               sys_brcst_out,
    output logic [1:0]               usr_brcst_out,
    output logic [15:0]              emu_cmd_out,
    output logic                     emu_cmd_valid_out,
    output logic [11:0]              local_bx_out,
    output logic [23:0]              local_ev_out,
    output logic                     orbit_err_out,
    output logic                     event_err_out,
    output logic                     q_warn_out,
    output logic                     q_err_out,
    output logic                     dbl_err_out,
    output logic                     sgl_err_out,
    output logic [7:0]               dbl_cnt_out,
    output logic [7:0]               sgl_cnt_out,
    output logic                     rx_reset_out,
    output logic [1:0]               receiver_control_setting_out,
    output logic                     cross_select_high_out,
    output logic                     cross_select_low_out,
    output logic [1:0]               phase_sel_out,
    output logic                     backplane_clk_en_out,
    output logic                     readout_driver_enable_out
);
    ttd_pkg::ttd_rx_t rx_m_ff, rx_s_ff;
    logic [23:0] ev_m_ff, ev_s_ff;
    logic [11:0] bxn_m_ff, bxn_s_ff;
    // two-stage synchronisers; only stage two is read
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rx_m_ff  <= '0;
            rx_s_ff  <= '0;
            ev_m_ff  <= '0;
            ev_s_ff  <= '0;
            bxn_m_ff <= '0;
            bxn_s_ff <= '0;
        end else begin
            rx_m_ff  <= rx_in;
            rx_s_ff  <= rx_m_ff;
            ev_m_ff  <= rx_event_in;
            ev_s_ff  <= ev_m_ff;
            bxn_m_ff <= rx_bunch_number_in;
            bxn_s_ff <= bxn_m_ff;
        end
    end
    logic [5:0] sys_dly;
    logic [1:0] usr_dly;
    ttd_delay #(.W(6)) u_sys_dly (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .dly_in (coarse_dly_in[ttd_pkg::DLY_SYS_LSB +: 4]),
        .d_in   (rx_s_ff.brcst[5:0]),
        .q_out  (sys_dly)
    );
    ttd_delay #(.W(2)) u_usr_dly (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .dly_in (coarse_dly_in[ttd_pkg::DLY_USR_LSB +: 4]),
        .d_in   (rx_s_ff.brcst[7:6]),
        .q_out  (usr_dly)
    );
    logic bcr_d_ff, ecr_d_ff;
    logic [11:0] bx_ff;
    logic [3:0] pat_mem [ttd_pkg::TBL_DEPTH];
    logic [15:0] cmd_mem [ttd_pkg::TBL_DEPTH];
    logic [3:0] pat;
    logic emu_bcr, bcr_any, bcr_rise, ecr_rise;
    assign pat      = pat_mem[bx_ff];
    assign emu_bcr  = emulate_in && pat[ttd_pkg::PAT_BCRES_BIT];
    assign bcr_rise = sys_dly[0] && !bcr_d_ff;
    assign ecr_rise = sys_dly[1] && !ecr_d_ff;
    assign bcr_any  = emulate_in ? emu_bcr : bcr_rise;
    // edge-shaped so a long broadcast still gives one bx pulse
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bcr_d_ff              <= 1'b0;
            ecr_d_ff              <= 1'b0;
            bunch_count_reset_out <= 1'b0;
            event_count_reset_out <= 1'b0;
            sys_brcst_out         <= '0;
            usr_brcst_out         <= '0;
            ro_reset_out          <= 1'b0;
        end else begin
            bcr_d_ff              <= sys_dly[0];
            ecr_d_ff              <= sys_dly[1];
            bunch_count_reset_out <= bcr_any;
            event_count_reset_out <= ecr_rise;
            sys_brcst_out         <= sys_dly[5:2];
            usr_brcst_out         <= usr_dly;
            ro_reset_out          <= bcr_any || ecr_rise;
        end
    end
    always_ff @(posedge clk_in) begin
        if (tbl_we_in) begin
            pat_mem[tbl_addr_in] <= tbl_pat_in;
            cmd_mem[tbl_addr_in] <= tbl_cmd_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bx_ff <= '0;
        end else if (bcr_any || bx_ff == ttd_pkg::ORBIT_LAST) begin
            bx_ff <= '0;
        end else begin
            bx_ff <= bx_ff + 12'h0_001;
        end
    end
    assign local_bx_out = bx_ff;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            emu_cmd_out       <= '0;
            emu_cmd_valid_out <= 1'b0;
        end else begin
            emu_cmd_out       <= cmd_mem[bx_ff];
            emu_cmd_valid_out <= emulate_in;
        end
    end
    logic trig, mon_ev, mon_st;
    logic [23:0] ev_ff;
    assign trig   = emulate_in ? (pat[ttd_pkg::PAT_TRIG_BIT] || host_trig_in) : rx_s_ff.trig;
    assign mon_ev = emulate_in && (pat[ttd_pkg::PAT_MONEV_BIT] || host_trig_in);
    assign mon_st = emulate_in && pat[ttd_pkg::PAT_MONST_BIT];
    always_ff @(posedge clk_in) begin
        if (rst_in || event_count_reset_out) begin
            ev_ff <= '0;
        end else if (trig) begin
            ev_ff <= ev_ff + 24'h00_0001;
        end
    end
    assign local_ev_out = ev_ff;
    // queue occupancy of trigger readout requests
    logic [4:0] q_lvl_ff;
    logic push, pop;
    assign push = trig && q_lvl_ff != ttd_pkg::Q_FULL_LEVEL;
    assign pop  = q_pop_in && q_lvl_ff != 5'h0_000;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            q_lvl_ff <= '0;
        end else if (push && !pop) begin
            q_lvl_ff <= q_lvl_ff + 5'h0_001;
        end else if (pop && !push) begin
            q_lvl_ff <= q_lvl_ff - 5'h0_001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            req_out       <= '0;
            req_valid_out <= 1'b0;
        end else begin
            req_valid_out     <= trig || mon_ev || mon_st;
            req_out.trig      <= trig;
            req_out.mon_event <= mon_ev;
            req_out.mon_stat  <= mon_st;
            req_out.bx        <= bx_ff;
            req_out.ev        <= ev_ff;
        end
    end
    // sticky flags: a new event wins over a clear in the same cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            orbit_err_out <= 1'b0;
            event_err_out <= 1'b0;
            q_warn_out    <= 1'b0;
            q_err_out     <= 1'b0;
            dbl_err_out   <= 1'b0;
            sgl_err_out   <= 1'b0;
        end else begin
            if (bcr_rise && !emulate_in && bx_ff != ttd_pkg::ORBIT_LAST) begin
                orbit_err_out <= 1'b1;
            end else if (flags_clr_in) begin
                orbit_err_out <= 1'b0;
            end
            if (rx_s_ff.trig && !emulate_in && ev_s_ff != ev_ff) begin
                event_err_out <= 1'b1;
            end else if (flags_clr_in) begin
                event_err_out <= 1'b0;
            end
            if (q_lvl_ff >= ttd_pkg::Q_WARN_LEVEL) begin
                q_warn_out <= 1'b1;
            end else if (flags_clr_in) begin
                q_warn_out <= 1'b0;
            end
            if (trig && q_lvl_ff == ttd_pkg::Q_FULL_LEVEL && !pop) begin
                q_err_out <= 1'b1;
            end else if (flags_clr_in) begin
                q_err_out <= 1'b0;
            end
            if (rx_s_ff.dbl_err) begin
                dbl_err_out <= 1'b1;
            end else if (flags_clr_in) begin
                dbl_err_out <= 1'b0;
            end
            if (rx_s_ff.sgl_err) begin
                sgl_err_out <= 1'b1;
            end else if (flags_clr_in) begin
                sgl_err_out <= 1'b0;
            end
        end
    end
    // counters saturate rather than wrap so a burst is never hidden
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dbl_cnt_out <= '0;
            sgl_cnt_out <= '0;
        end else begin
            if (rx_s_ff.dbl_err && dbl_cnt_out != 8'h00_FF) begin
                dbl_cnt_out <= dbl_cnt_out + 8'h00_01;
            end
            if (rx_s_ff.sgl_err && sgl_cnt_out != 8'h00_FF) begin
                sgl_cnt_out <= sgl_cnt_out + 8'h00_01;
            end
        end
    end
    logic [4:0] rxr_cnt_ff;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rxr_cnt_ff <= '0;
        end else if (host_rx_reset_in) begin
            rxr_cnt_ff <= 5'(ttd_pkg::RX_RST_CYC);
        end else if (rxr_cnt_ff != 5'h0_000) begin
            rxr_cnt_ff <= rxr_cnt_ff - 5'h0_001;
        end
    end
    assign rx_reset_out                 = rxr_cnt_ff != 5'h0_000;
    assign receiver_control_setting_out = ttd_pkg::RX_CTRL_EVONLY;
    // forbidden select falls back to the safe routing
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            {cross_select_high_out, cross_select_low_out} <= ttd_pkg::XSEL_RX_ALL;
            phase_sel_out <= '0;
        end else begin
            if (cross_sel_in == ttd_pkg::XSEL_FORBIDDEN) begin
                {cross_select_high_out, cross_select_low_out} <= ttd_pkg::XSEL_RX_ALL;
            end else begin
                {cross_select_high_out, cross_select_low_out} <= cross_sel_in;
            end
            phase_sel_out <= phase_sel_in;
        end
    end
    logic [31:0] pwr_cnt_ff;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pwr_cnt_ff                <= '0;
            backplane_clk_en_out      <= 1'b0;
            readout_driver_enable_out <= 1'b0;
        end else begin
            if (pwr_cnt_ff != 32'(READOUT_DRIVER_ENABLE_CYC)) begin
                pwr_cnt_ff <= pwr_cnt_ff + 32'h0000_0001;
            end
            if (pwr_cnt_ff >= 32'(PWRUP_CYC)) begin
                backplane_clk_en_out <= 1'b1;
            end
            if (pwr_cnt_ff == 32'(READOUT_DRIVER_ENABLE_CYC)) begin
                readout_driver_enable_out <= 1'b1;
            end
        end
    end
    sequence s_bcr_in;
        bcr_any;
    endsequence
    a_bcr_clears_bx: assert property (@(posedge clk_in) disable iff (rst_in)
        s_bcr_in |=> bx_ff == 12'h0_000) else $error("bx not cleared");
    a_bcr_pulse_one: assert property (@(posedge clk_in) disable iff (rst_in)
        bunch_count_reset_out && !emulate_in |=> !bunch_count_reset_out) else $error("bcr wide");
    a_ecr_pulse_one: assert property (@(posedge clk_in) disable iff (rst_in)
        event_count_reset_out |=> !event_count_reset_out) else $error("ecr wide");
    a_bx_wraps: assert property (@(posedge clk_in) disable iff (rst_in)
        bx_ff == ttd_pkg::ORBIT_LAST |=> bx_ff == 12'h0_000) else $error("no wrap");
    a_orbit_check: assert property (@(posedge clk_in) disable iff (rst_in)
        bcr_rise && !emulate_in && bx_ff != ttd_pkg::ORBIT_LAST |=> orbit_err_out) else $error("orbit");
    a_event_check: assert property (@(posedge clk_in) disable iff (rst_in)
        rx_s_ff.trig && !emulate_in && ev_s_ff != ev_ff |=> event_err_out) else $error("event");
    a_xsel_safe: assert property (@(posedge clk_in) disable iff (rst_in)
        !(cross_select_high_out && !cross_select_low_out)) else $error("bad xsel");
    a_err_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
        rx_s_ff.dbl_err |=> dbl_err_out) else $error("dbl flag");
    a_req_bx: assert property (@(posedge clk_in) disable iff (rst_in)
        trig |=> req_valid_out && req_out.bx == $past(bx_ff)) else $error("req bx");
    a_rxrst_len: assert property (@(posedge clk_in) disable iff (rst_in)
        host_rx_reset_in |=> rx_reset_out [*8]) else $error("rx reset short");
    a_ro_late: assert property (@(posedge clk_in) disable iff (rst_in)
        readout_driver_enable_out |-> backplane_clk_en_out) else $error("ro early");
endmodule

// [test/ttd_rx_model.sv]
// receiver stand-in: broadcast levels, error strobes, trigger with event number
// assumes its tasks are called just after a rising edge of clk_in
`timescale 1ns/1ps
module ttd_rx_model (
    input  wire logic        clk_in,
    output ttd_pkg::ttd_rx_t rx_out,
    output logic [23:0]      event_out,
    output logic [11:0]      bunch_out
);
    initial begin
        rx_out = '0;
        event_out = '0;
        bunch_out = '0;
    end
    // no valid bunch number without a trigger, so keep it moving
    always @(posedge clk_in) begin
        if (rx_out.trig !== 1'b1) begin
            bunch_out <= ~bunch_out;
        end
    end
    task automatic set(input logic [10:0] v);
        @(posedge clk_in);
        rx_out <= v;
    endtask
    task automatic pulse(input logic [10:0] v);
        set(v);
        set(11'h000);
    endtask
    // event number is only held for the trigger cycle, then scrambled
    task automatic trig(input logic [23:0] ev);
        @(posedge clk_in);
        event_out <= ev;
        rx_out.trig <= 1'b1;
        @(posedge clk_in);
        rx_out.trig <= 1'b0;
        event_out <= ~ev;
    endtask
    // after a receiver reset both counter resets follow
    task automatic resync();
        pulse(11'h008);
        pulse(11'h010);
    endtask
endmodule

// [test/testbench.sv]
// bench for ttd_top with receiver stand-in and integer reference
// assumes shortened power-up counts and a 50 MHz clock
`timescale 1ns/1ps
module testbench;
    localparam int PW = 10;
    localparam int RO = 20;
    ttd_pkg::ttd_rx_t  rx;
    ttd_pkg::ttd_req_t req;
    logic [23:0] rx_ev, lev;
    logic [11:0] rx_bn, lbx, ta = '0;
    logic [15:0] tc = '0, cmd;
    logic [7:0]  dly = '0, dcnt, scnt;
    logic [3:0]  tp = '0, sys;
    logic [1:0]  xs = '0, ps = '0, ctl, pso, usr;
    logic        clk_in, rst_in = 1, emu = 0, htrig = 0, hrst = 0, fclr = 0, twe = 0, qpop = 0;
    logic        reqv, ror, bcr, ecr, cmdv, oerr, eerr, qw, qe, de, se, rxr, xh, xl, bpen, roen;
    int          error_cnt = 0, total_checks = 0, cyc = 0, n, m, mev = 0, d, u, s, w;
    ttd_rx_model rxm (.clk_in(clk_in), .rx_out(rx), .event_out(rx_ev), .bunch_out(rx_bn));
    ttd_top #(.PWRUP_CYC(PW), .READOUT_DRIVER_ENABLE_CYC(RO)) dut (
        .clk_in(clk_in), .rst_in(rst_in), .rx_in(rx), .rx_event_in(rx_ev), .rx_bunch_number_in(rx_bn),
        .coarse_dly_in(dly), .emulate_in(emu), .host_trig_in(htrig), .host_rx_reset_in(hrst),
        .cross_sel_in(xs), .phase_sel_in(ps), .flags_clr_in(fclr), .tbl_we_in(twe), .tbl_addr_in(ta),
        .tbl_pat_in(tp), .tbl_cmd_in(tc), .q_pop_in(qpop), .req_out(req), .req_valid_out(reqv),
        .ro_reset_out(ror), .bunch_count_reset_out(bcr), .event_count_reset_out(ecr), .sys_brcst_out(sys),
        .usr_brcst_out(usr), .emu_cmd_out(cmd), .emu_cmd_valid_out(cmdv), .local_bx_out(lbx),
        .local_ev_out(lev), .orbit_err_out(oerr), .event_err_out(eerr), .q_warn_out(qw), .q_err_out(qe),
        .dbl_err_out(de), .sgl_err_out(se), .dbl_cnt_out(dcnt), .sgl_cnt_out(scnt), .rx_reset_out(rxr),
        .receiver_control_setting_out(ctl), .cross_select_high_out(xh), .cross_select_low_out(xl),
        .phase_sel_out(pso), .backplane_clk_en_out(bpen), .readout_driver_enable_out(roen));
    initial begin
        clk_in = 0;
        forever #10 clk_in = ~clk_in;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // whole run is about 16k cycles
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic nx(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask
    task automatic clr();
        @(posedge clk_in);
        fclr <= 1;
        @(posedge clk_in);
        fclr <= 0;
    endtask
    function automatic logic [3:0] pick(input int sel);
        case (sel)
            0: return {3'b0, bcr};
            1: return {3'b0, ecr};
            2: return sys;
            default: return {2'b0, usr};
        endcase
    endfunction
    task automatic lat(input int sel, input logic [3:0] v, output int c);
        c = 0;
        do begin
            nx(1);
            c++;
        end while (pick(sel) !== v && c < 40);
    endtask
    // drains one queued trigger; requests leave at trigger time, not at pop
    task automatic pop();
        @(posedge clk_in);
        qpop <= 1;
        @(posedge clk_in);
        qpop <= 0;
    endtask
    // receiver trigger; its readout request stands two edges after the model returns
    task automatic trg(input int e, input int x);
        rxm.trig(24'(e));
        nx(2);
        chk("req_trig", 1, reqv === 1'b1 && req.trig === 1'b1 && req.bx <= ttd_pkg::ORBIT_LAST);
        chk("req_ev", x, req.ev);
    endtask
    initial begin
        void'($urandom(26));
        repeat (12) @(posedge clk_in);
        rst_in <= 0;
        nx(1);
        chk("bcr_rst", 0, bcr);
        chk("rx_ctrl", ttd_pkg::RX_CTRL_EVONLY, ctl);
        n = 0;
        m = 0;
        for (int i = 1; i <= 40; i++) begin
            nx(1);
            if (bpen === 1'b1 && n == 0) n = i;
            if (roen === 1'b1 && m == 0) m = i;
        end
        chk("bp_en_time", 1, n >= PW - 2 && n <= PW + 3);
        chk("ro_en_time", 1, m >= RO - 2 && m <= RO + 3);
        $display("test powerup done");
        for (int k = 0; k < 4; k++) begin
            d = (k == 0) ? 0 : $urandom % 16;
            u = (k == 0) ? 15 : $urandom % 16;
            s = 1 + $urandom % 15;
            w = 1 + $urandom % 3;
            @(posedge clk_in);
            dly <= {u[3:0], d[3:0]};
            rxm.pulse(11'h008);
            lat(0, 4'h1, n);
            chk("bcr_delay", d + 3, n);
            nx(1);
            chk("bcr_width", 0, bcr);
            rxm.pulse(11'h010);
            lat(1, 4'h1, n);
            chk("ecr_delay", d + 3, n);
            nx(1);
            chk("ecr_width", 0, ecr);
            rxm.set({2'b00, s[3:0], 5'b0});
            lat(2, s[3:0], n);
            chk("sys_delay", d + 4, n);
            rxm.set({w[1:0], s[3:0], 5'b0});
            lat(3, {2'b0, w[1:0]}, n);
            chk("usr_delay", u + 4, n);
            rxm.set(11'h000);
            n = 0;
            // host controls outside emulation must not raise requests
            repeat (40) begin
                @(posedge clk_in);
                htrig <= 1'($urandom);
                qpop  <= 1'($urandom);
                twe   <= 1'($urandom);
                n += (reqv !== 1'b0);
            end
            @(posedge clk_in);
            htrig <= 0;
            qpop  <= 0;
            twe   <= 0;
            chk("no_req", 0, n);
        end
        $display("test broadcast done");
        @(posedge clk_in);
        dly <= 8'h00;
        rxm.pulse(11'h008);
        repeat (9) @(posedge clk_in);
        clr();
        repeat (3552) @(posedge clk_in);
        rxm.pulse(11'h008);
        nx(8);
        chk("orbit_ok", 0, oerr);
        chk("bx_cleared", 1, lbx < 12);
        repeat (100) @(posedge clk_in);
        rxm.pulse(11'h008);
        nx(8);
        chk("orbit_bad", 1, oerr);
        $display("test orbit done");
        rxm.pulse(11'h010);
        nx(8);
        chk("ev_cleared", 0, lev);
        clr();
        repeat (3) begin
            trg(mev, mev);
            mev++;
        end
        nx(6);
        chk("ev_match", 0, eerr);
        chk("ev_count", mev, lev);
        trg(mev + 5, mev);
        nx(6);
        chk("ev_mismatch", 1, eerr);
        repeat (4) pop();
        $display("test event done");
        clr();
        for (int i = 1; i <= 17; i++) begin
            trg(mev, 3 + i);
            nx(4);
            if (i == 11 || i == 12) chk("q_warn", i >= 12, qw);
            if (i == 16 || i == 17) chk("q_err", i > ttd_pkg::Q_DEPTH, qe);
        end
        repeat (4) pop();
        clr();
        nx(2);
        chk("q_drained", 1, qw);
        pop();
        clr();
        nx(2);
        chk("q_warn_clr", 0, qw);
        repeat (12) pop();
        $display("test queue done");
        repeat (3) rxm.pulse(11'h002);
        repeat (2) rxm.pulse(11'h001);
        nx(6);
        chk("dbl_flag", 1, de);
        chk("dbl_cnt", 3, dcnt);
        chk("sgl_flag", 1, se);
        chk("sgl_cnt", 2, scnt);
        clr();
        nx(3);
        chk("err_clr", 0, {de, se});
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in);
            xs <= i[1:0];
            ps <= 2'd3 - i[1:0];
            nx(3);
            chk("cross", (i == 2) ? 0 : i, {xh, xl});
            chk("phase", 3 - i, pso);
        end
        $display("test errors and selects done");
        @(posedge clk_in);
        hrst <= 1;
        @(posedge clk_in);
        hrst <= 0;
        #1;
        n = 0;
        repeat (30) begin
            n += rxr;
            nx(1);
        end
        chk("rx_reset_len", ttd_pkg::RX_RST_CYC, n);
        rxm.resync();
        nx(8);
        chk("resync_ev", 0, lev);
        $display("test receiver reset done");
        for (int a = 0; a < ttd_pkg::TBL_DEPTH; a++) begin
            @(posedge clk_in);
            twe <= 1;
            ta <= a[11:0];
            tp <= (a == 5) ? 4'h2 : {1'b0, 1'($urandom), 2'b00}; // random statistics bits only
            tc <= {4'h0, a[11:0]};
        end
        @(posedge clk_in);
        twe <= 0;
        emu <= 1;
        m = 0;
        n = 0;
        s = 0;
        u = 0;
        repeat (3600) begin
            nx(1);
            if (lbx > m) m = lbx;
            if (reqv === 1'b1 && req.mon_event === 1'b1) n++;
            if (cmdv === 1'b1) u++;
            if (cmdv === 1'b1 && cmd > {4'h0, ttd_pkg::ORBIT_LAST}) s++;
        end
        chk("bx_last", ttd_pkg::ORBIT_LAST_BX, m);
        chk("mon_seen", 1, n > 0);
        chk("cmd_seen", 1, u > 0);
        chk("cmd_bad", 0, s);
        @(posedge clk_in);
        twe <= 1;
        ta <= 12'h005;
        tp <= 4'h0;
        @(posedge clk_in);
        ta <= 12'h00A;
        tp <= 4'h8;
        @(posedge clk_in);
        twe <= 0;
        repeat (3600) @(posedge clk_in);
        m = 0;
        repeat (50) begin
            nx(1);
            if (lbx > m) m = lbx;
        end
        chk("bx_short", 1, m >= 9 && m <= 12);
        @(posedge clk_in);
        htrig <= 1;
        @(posedge clk_in);
        htrig <= 0;
        #1;
        chk("host_mon", 1, reqv === 1'b1 && req.mon_event === 1'b1);
        chk("host_trig", 1, reqv === 1'b1 && req.trig === 1'b1);
        n = 0;
        repeat (10) begin
            nx(1);
            if (reqv === 1'b1 && req.mon_event === 1'b1) n++;
        end
        chk("host_once", 0, n);
        pop();
        $display("test emulation done");
        finish_test();
    end
endmodule
